// *** sdd_pkg.sv ***
/*
 * Constants shared by the sigma-delta decimator: timing, thresholds,
 * result widths and the serial frame layout.
 * Assumes a single 100 MHz system clock.
 */
package sdd_pkg;

    // Clock and timing figures in their own units.
    localparam int CLK_HZ         = 100_000_000;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SAMPLE_PERIOD_NS = 50_000;
    localparam int BIT_RATE_BPS   = 19_200;

    // Derived cycle counts; the sample period is exact, the bit period
    // rounds down to whole cycles.
    localparam int TICK_CYCLES_DEF = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BIT_CYCLES_DEF  = CLK_HZ / BIT_RATE_BPS;

    // Modulator and decimator figures.
    localparam logic [7:0]  THRESHOLD     = 8'h37;
    localparam int          RESULT_W      = 11;
    localparam logic [10:0] SAMPLES_PER_RESULT = 11'h400;
    localparam logic [2:0]  SENSE_CHANNEL = 3'h1;

    // Serial frame: two sync bytes, then result high and low.
    localparam logic [7:0]  SYNC_BYTE     = 8'hFF;
    localparam logic [1:0]  LAST_FRAME_IDX = 2'h3;
    localparam logic [3:0]  TX_DATA_BITS  = 4'h9;
    localparam int          FIFO_DEPTH    = 4;
    localparam int          FIFO_WIDTH    = 8;

    // Sample step sequencer states.
    typedef enum logic [1:0] {
        SDD_WAIT_TICK = 2'b00,
        SDD_CONVERT   = 2'b01
    } sdd_state_t;

endpackage

// *** sdd_decimator.sv ***
/*
 * Sigma-delta modulator loop, counting decimator and serial result
 * sender, plus the byte FIFO between frame builder and transmitter.
 * Assumes the on-chip A/D converter sits on the same clock, starts on
 * a one-cycle pulse and answers with a one-cycle done and its data.
 */
// Operation
// - One sample step per 50 us tick.
// - One result every 1024 sample steps.
// - Clear tick request, then convert sense channel x8.
// - Compare conversion against threshold 037h.
// - Below threshold: feedback high, count sample only.
// - Above threshold: feedback low, count one and sample.
// - Below 1024 samples the step just ends.
// - At 1024: store result, flag, clear counters.
// - Counters start from zero after reset.
// - Sender waits for flag, then transmits result.
// - Serial bit rate is 19200 bits per second.
// - Each byte: start low, eight data, stop high.
`timescale 1ns/1ps

module sdd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    // Pointer width, and a count that also holds the full depth.
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // Storage, both pointers and the fill count are the whole state.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               cnt;
    } sdd_fifo_st_t;

    // Registered state, its next value and the two transfer strobes.
    sdd_fifo_st_t st;
    sdd_fifo_st_t next_st;
    logic         push;
    logic         pop;

    // Full and empty follow the stored count directly.
    assign in_ready  = (st.cnt != CW'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointers wrap at the depth, so any depth is allowed.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == PW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == PW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        // A push and a pop together leave the count as it is.
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    // State register; the storage itself needs no reset.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st.wr  <= '0;
            st.rd  <= '0;
            st.cnt <= '0;
            st.mem <= st.mem;
        end else begin
            st <= next_st;
        end
    end
endmodule

module sdd_decimator
    import sdd_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int BIT_CYCLES  = BIT_CYCLES_DEF
) (
    // Clock and synchronous reset.
    input  wire logic                clk_sys,
    input  wire logic                srst,
    // Converter handshake, channel and gain.
    output logic                     adc_start,
    output logic      [2:0]          sense_input_channel,
    output logic                     adc_gain_x8,
    input  wire logic                adc_done,
    input  wire logic [7:0]          adc_data,
    // Loop feedback and the decimated result.
    output logic                     feedback_out,
    output logic      [RESULT_W-1:0] result,
    output logic                     new_result_flag,
    // Serial line and sample tick strobe.
    output logic                     serial_tx_line,
    output logic                     sample_tick
);
    typedef struct packed {
        // Step sequencer, sample timer and conversion start.
        sdd_state_t          state;
        logic [15:0]         tick_cnt;
        logic                tick;
        logic                tick_pend;
        logic                start;

        // Modulator feedback, counters and the held result.
        logic                feedback;
        logic [RESULT_W-1:0] samples;
        logic [RESULT_W-1:0] ones;
        logic [RESULT_W-1:0] result;
        logic                flag;

        // Frame builder: busy, byte index and latched word.
        logic                ld_busy;
        logic [1:0]          ld_idx;
        logic [RESULT_W-1:0] ld_word;

        // Transmitter: shifter, bit count and bit timer.
        logic                tx_busy;
        logic [8:0]          tx_shift;
        logic [3:0]          tx_bits;
        logic [15:0]         tx_cnt;
        logic                tx_line;
    } sdd_st_t;

    // Registered state and its next value.
    sdd_st_t     st;
    sdd_st_t     next_st;

    // Builder and transmitter sides of the byte FIFO.
    logic [7:0]  push_data;
    logic        push_ready;
    logic        pop_valid;
    logic        pop_ready;
    logic [7:0]  pop_data;
    logic        take;
    logic        done_result;

    // The sense channel with gain is the only conversion ever asked for.
    assign sense_input_channel = SENSE_CHANNEL;
    assign adc_gain_x8         = 1'b1;
    assign adc_start           = st.start;
    assign feedback_out        = st.feedback;
    assign result              = st.result;
    assign new_result_flag     = st.flag;
    assign serial_tx_line      = st.tx_line;
    assign sample_tick         = st.tick;

    // Frame builder feeds sync bytes, then result high and low bytes.
    always_comb begin
        case (st.ld_idx)
            2'h2:    push_data = {5'h00, st.ld_word[10:8]};
            2'h3:    push_data = st.ld_word[7:0];
            default: push_data = SYNC_BYTE;
        endcase
    end

    // The builder takes a result only when it is idle.
    assign take      = st.flag && !st.ld_busy;

    // The transmitter pops a byte only while it is idle.
    assign pop_ready = !st.tx_busy;

    // The answer that completes the 1024th sample closes a result.
    assign done_result = (st.state == SDD_CONVERT) && adc_done &&
                         (st.samples + 1'b1 == SAMPLES_PER_RESULT);

    // Slack of four bytes lets the builder run ahead of the line.
    sdd_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_valid  (st.ld_busy),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    // Next state of timer, modulator step, frame builder and transmitter.
    always_comb begin
        next_st = st;
        next_st.start = 1'b0;
        next_st.tick  = 1'b0;

        // Periodic sample tick; a pending request survives a clear.
        if (st.tick_cnt == 16'(TICK_CYCLES - 1)) begin
            next_st.tick_cnt = '0;
            next_st.tick     = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 1'b1;
        end

        // Sample step: start one conversion, then judge its answer.
        case (st.state)
            SDD_WAIT_TICK: begin
                if (st.tick_pend) begin
                    next_st.tick_pend = 1'b0;
                    next_st.start     = 1'b1;
                    next_st.state     = SDD_CONVERT;
                end
            end
            SDD_CONVERT: begin
                if (adc_done) begin
                    next_st.state   = SDD_WAIT_TICK;
                    next_st.samples = st.samples + 1'b1;
                    // A value equal to the threshold counts as high.
                    if (adc_data < THRESHOLD) begin
                        next_st.feedback = 1'b1;
                    end else begin
                        next_st.feedback = 1'b0;
                        next_st.ones     = st.ones + 1'b1;
                    end
                    // Below the full count the step simply ends.
                    if (done_result) begin
                        next_st.result  = next_st.ones;
                        next_st.samples = '0;
                        next_st.ones    = '0;
                    end
                end
            end
            default: next_st.state = SDD_WAIT_TICK;
        endcase
        // A tick arriving mid-step waits; the set wins over the clear.
        if (st.tick) begin
            next_st.tick_pend = 1'b1;
        end

        // Flag: a new result wins over the take in the same cycle.
        if (done_result) begin
            next_st.flag = 1'b1;
        end else if (take) begin
            next_st.flag = 1'b0;
        end

        // Frame builder pushes four bytes, stalling on a full FIFO.
        if (take) begin
            next_st.ld_busy = 1'b1;
            next_st.ld_idx  = '0;
            next_st.ld_word = st.result;
        end else if (st.ld_busy && push_ready) begin
            if (st.ld_idx == LAST_FRAME_IDX) begin
                next_st.ld_busy = 1'b0;
            end
            next_st.ld_idx = st.ld_idx + 1'b1;
        end

        // Transmitter: start bit, eight data bits LSB first, stop bit.
        // One idle clock follows each stop bit before the next byte.
        if (!st.tx_busy) begin
            if (pop_valid) begin
                next_st.tx_busy  = 1'b1;
                next_st.tx_line  = 1'b0;
                next_st.tx_shift = {1'b1, pop_data};
                next_st.tx_bits  = TX_DATA_BITS;
                next_st.tx_cnt   = '0;
            end
        end else if (st.tx_cnt == 16'(BIT_CYCLES - 1)) begin
            next_st.tx_cnt = '0;
            if (st.tx_bits == '0) begin
                next_st.tx_busy = 1'b0;
            end else begin
                next_st.tx_line  = st.tx_shift[0];
                next_st.tx_shift = {1'b1, st.tx_shift[8:1]};
                next_st.tx_bits  = st.tx_bits - 1'b1;
            end
        end else begin
            next_st.tx_cnt = st.tx_cnt + 1'b1;
        end
    end

    // State register; reset clears both counters and idles the line.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st          <= '0;
            st.state    <= SDD_WAIT_TICK;
            st.feedback <= 1'b1;
            st.tx_line  <= 1'b1;
            st.tx_shift <= 9'h1FF;
        end else begin
            st <= next_st;
        end
    end
endmodule

// *** sdd_chk_sva.sv ***
/*
 * Port checker for the sigma-delta decimator.
 * Assumes it is bound to the top module from tb_top with its parameters.
 */
`timescale 1ns/1ps
module sdd_chk
    import sdd_pkg::*;
#(
    parameter int TICK_CYCLES = 20,
    parameter int BIT_CYCLES  = 4
) (
    input wire logic                clk_sys,
    input wire logic                srst,
    input wire logic                adc_start,
    input wire logic [2:0]          sense_input_channel,
    input wire logic                adc_gain_x8,
    input wire logic                adc_done,
    input wire logic [7:0]          adc_data,
    input wire logic                feedback_out,
    input wire logic [RESULT_W-1:0] result,
    input wire logic                new_result_flag,
    input wire logic                serial_tx_line,
    input wire logic                sample_tick
);
    int   gap;
    logic seen;

    // Counts cycles since the last tick; the first tick only arms it.
    always_ff @(posedge clk_sys) begin
        gap  <= (srst || sample_tick) ? 0 : gap + 1;
        seen <= srst ? 1'h0 : (seen | sample_tick);
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_tick_period: assert property (sample_tick && seen |-> gap == TICK_CYCLES - 1)
        else $error("tick period wrong");
    // The tick is first kept as a pending request, so start is two on.
    a_start_follow: assert property (sample_tick |-> ##2 adc_start)
        else $error("no conversion after tick");
    a_start_pulse: assert property (adc_start |=> !adc_start)
        else $error("start not a pulse");
    a_chan_gain: assert property (adc_start |-> sense_input_channel == SENSE_CHANNEL && adc_gain_x8)
        else $error("wrong channel or gain");
    a_fb_below: assert property (adc_done && adc_data < THRESHOLD |=> feedback_out)
        else $error("feedback not high");
    a_fb_above: assert property (adc_done && adc_data >= THRESHOLD |=> !feedback_out)
        else $error("feedback not low");
    a_result_hold: assert property (!$rose(new_result_flag) |-> $stable(result))
        else $error("result moved without flag");
    a_flag_taken: assert property ($rose(new_result_flag) |-> ##[1:300] !new_result_flag)
        else $error("result never taken");
    a_start_bit: assert property ($fell(serial_tx_line) |-> (!serial_tx_line)[*3])
        else $error("serial low bit too short");

    c_tick: cover property (sample_tick);
    c_result: cover property ($rose(new_result_flag));
    c_frame: cover property ($fell(serial_tx_line));
endmodule

// *** sdd_adc_model.sv ***
/*
 * Behavioural model of the on-chip converter seen by the decimator.
 * Assumes the bench sets the sampled level and the answer latency.
 */
`timescale 1ns/1ps
module sdd_adc_model (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       adc_start,
    input  wire logic [7:0] level,
    input  wire logic [3:0] lat,
    output logic            adc_done,
    output logic [7:0]      adc_data
);
    int   wait_cnt = 0;
    logic busy     = 1'h0;

    // Answers each start lat + 1 cycles later; data is garbled outside done.
    always @(posedge clk_sys) begin
        #1;
        if (srst) begin
            busy     = 1'h0;
            adc_done = 1'h0;
            adc_data = 8'h00;
        end else if (adc_done) begin
            adc_done = 1'h0;
            adc_data = ~adc_data;
        end else if (busy && wait_cnt == 0) begin
            adc_done = 1'h1;
            adc_data = level;
            busy = 1'h0;
        end else if (busy) begin
            wait_cnt--;
        end else if (adc_start) begin
            busy = 1'h1;
            wait_cnt = lat;
        end
    end
endmodule

// *** tb_top.sv ***
/*
 * Self-checking bench for the sigma-delta decimator.
 * Assumes short tick and bit periods so two results fit in one run.
 */
`timescale 1ns/1ps
module tb_top;
    import sdd_pkg::*;
    localparam int TCK = 20;
    localparam int BCK = 4;
    logic                clk_sys = 1'h0;
    logic                srst    = 1'h1;
    logic [7:0]          level   = 8'h37;
    logic [3:0]          lat     = 4'h1;
    logic                adc_start, adc_done, feedback_out;
    logic                new_result_flag, serial_tx_line;
    logic [7:0]          adc_data;
    logic [RESULT_W-1:0] result;
    int                  fail_count = 0;
    int                  cmp_count  = 0;

    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;

    sdd_decimator #(.TICK_CYCLES(TCK), .BIT_CYCLES(BCK)) uut (
        .clk_sys(clk_sys), .srst(srst), .adc_start(adc_start),
        .sense_input_channel(), .adc_gain_x8(), .adc_done(adc_done),
        .adc_data(adc_data), .feedback_out(feedback_out),
        .result(result), .new_result_flag(new_result_flag),
        .serial_tx_line(serial_tx_line), .sample_tick());

    sdd_adc_model adc (.clk_sys(clk_sys), .srst(srst),
        .adc_start(adc_start), .level(level), .lat(lat),
        .adc_done(adc_done), .adc_data(adc_data));

    task automatic cmp(input string what, input logic [10:0] exp,
                       input logic [10:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_flag;
        for (int i = 0; i < 25000 && new_result_flag !== 1'h1; i++) step(1);
        if (new_result_flag !== 1'h1) begin
            fail_count++;
            test_done();
        end
    endtask

    // Receives one byte, sampling each bit in its middle.
    task automatic get_byte(output logic [7:0] b);
        for (int i = 0; i < 200 && serial_tx_line !== 1'h0; i++) step(1);
        if (serial_tx_line !== 1'h0) begin
            fail_count++;
            test_done();
        end
        step(BCK / 2);
        cmp("start bit", 11'h000, {10'h000, serial_tx_line});
        for (int i = 0; i < 8; i++) begin
            step(BCK);
            b[i] = serial_tx_line;
        end
        step(BCK);
        cmp("stop bit", 11'h001, {10'h000, serial_tx_line});
    endtask

    task automatic t_reset;
        cmp("result", 11'h000, result);
        cmp("feedback", 11'h001, {10'h000, feedback_out});
        cmp("tx idle", 11'h001, {10'h000, serial_tx_line});
    endtask

    // Every sample equals the threshold, so all 1024 count as ones.
    task automatic t_full_count;
        logic [7:0] b;
        logic [7:0] exp_b [4] = '{8'hFF, 8'hFF, 8'h04, 8'h00};
        wait_flag();
        level = 8'h36;
        lat   = 4'h9;
        cmp("result", 11'h400, result);
        cmp("feedback", 11'h000, {10'h000, feedback_out});
        for (int k = 0; k < 4; k++) begin
            get_byte(b);
            cmp("byte", {3'h0, exp_b[k]}, {3'h0, b});
        end
        cmp("flag", 11'h000, {10'h000, new_result_flag});
    endtask

    // A slow converter and all samples below: counters restart at zero.
    task automatic t_zero;
        wait_flag();
        cmp("result", 11'h000, result);
        cmp("feedback", 11'h001, {10'h000, feedback_out});
    endtask

    // Main sequence.
    initial begin
        step(2);
        srst = 1'h0;
        t_reset();
        t_full_count();
        t_zero();
        test_done();
    end
endmodule

bind sdd_decimator sdd_chk #(.TICK_CYCLES(TICK_CYCLES),
    .BIT_CYCLES(BIT_CYCLES)) chk (.clk_sys(clk_sys), .srst(srst),
    .adc_start(adc_start), .sense_input_channel(sense_input_channel),
    .adc_gain_x8(adc_gain_x8), .adc_done(adc_done), .adc_data(adc_data),
    .feedback_out(feedback_out), .result(result),
    .new_result_flag(new_result_flag), .serial_tx_line(serial_tx_line),
    .sample_tick(sample_tick));
